/* design/flash_id_pkg.sv */
`default_nettype none
package flash_id_pkg;
   localparam logic [7:0] OP_RESUME       = 8'h7A;
   localparam logic [7:0] OP_SUSPEND      = 8'h75;
   localparam logic [7:0] OP_POWER_DOWN   = 8'hB9;
   localparam logic [7:0] OP_RELEASE_ID   = 8'hAB;
   localparam logic [7:0] OP_MFR_DEV_ID   = 8'h90;
   localparam logic [7:0] OP_MFR_DEV_DUAL = 8'h92;
   localparam logic [7:0] OP_MFR_DEV_QUAD = 8'h94;
   localparam logic [7:0] OP_UNIQUE_ID    = 8'h4B;
   localparam logic [7:0] MODE_BITS       = 8'hF0;
   localparam int         OPCODE_BITS     = 8;
   localparam int         MODE_W          = 8;
   localparam int         ADDR3_BITS      = 24;
   localparam int         ADDR4_BITS      = 32;
   localparam int         QUAD_DUMMY_CLKS = 4;
   localparam int         UID_DUMMY_CLKS  = 32;
   localparam logic [5:0] SKIP_SINGLE = 6'(ADDR3_BITS);
   localparam logic [5:0] SKIP_UID    = 6'(UID_DUMMY_CLKS);
   localparam logic [5:0] SKIP_DUAL3  = 6'((ADDR3_BITS + MODE_W) / 2);
   localparam logic [5:0] SKIP_DUAL4  = 6'((ADDR4_BITS + MODE_W) / 2);
   localparam logic [5:0] SKIP_QUAD3  = 6'(QUAD_DUMMY_CLKS + (ADDR3_BITS + MODE_W) / 4);
   localparam logic [5:0] SKIP_QUAD4  = 6'(QUAD_DUMMY_CLKS + (ADDR4_BITS + MODE_W) / 4);
   localparam logic [5:0] MODE_CLKS_DUAL = 6'(MODE_W / 2);
   localparam logic [5:0] MODE_CLKS_QUAD = 6'(MODE_W / 4);
   localparam int CLK_PERIOD_NS    = 5;
   localparam int RESUME_BUSY_NS   = 200;
   localparam int RESUME_BUSY_CYC  = RESUME_BUSY_NS / CLK_PERIOD_NS;
   localparam int PD_ENTRY_NS      = 3000;
   localparam int PD_ENTRY_CYC     = (PD_ENTRY_NS / CLK_PERIOD_NS > 0) ?
                                     PD_ENTRY_NS / CLK_PERIOD_NS : 1;
   localparam int RELEASE_NS       = 3000;
   localparam int RELEASE_CYC      = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SUSPEND_GUARD_NS = 20000;
   localparam int SUSPEND_GUARD_CYC = SUSPEND_GUARD_NS / CLK_PERIOD_NS;
   localparam int SCLK_HALF_CYC    = 8;
   localparam int CNT_W            = 16;
   typedef enum logic [1:0] {PH_OPC, PH_SKIP, PH_OUT, PH_IGNORE} dev_phase_t;
   typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL, H_GAP} host_state_t;

   function automatic logic [3:0] lane_bits(input logic [2:0] w, input logic [7:0] d);
      unique case (w)
         3'd2:    lane_bits = {2'b00, d[7:6]};
         3'd4:    lane_bits = d[7:4];
         default: lane_bits = {3'b000, d[7]};
      endcase
   endfunction : lane_bits

   function automatic logic [3:0] lane_enable(input logic [2:0] w);
      unique case (w)
         3'd2:    lane_enable = 4'h3;
         3'd4:    lane_enable = 4'hF;
         default: lane_enable = 4'h1;
      endcase
   endfunction : lane_enable
endpackage : flash_id_pkg
`default_nettype wire

/* design/flash_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface flash_link_if;
   logic       csN;
   logic       sclk;
   logic [3:0] hostOut;
   logic [3:0] hostOe;
   logic [3:0] devOut;
   logic [3:0] devOe;
   logic [3:0] io;

   // Undriven lanes float high, as with the usual pull-ups.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         io[i] = devOe[i] ? devOut[i] : (hostOe[i] ? hostOut[i] : 1'b1);
      end
   end

   modport host   (output csN, output sclk, output hostOut, output hostOe, input io);
   modport device (input csN, input sclk, input io, output devOut, output devOe);
endinterface : flash_link_if
`default_nettype wire

/* design/flash_id_device.sv */
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Resume only when suspended and not busy.
// - Resume clears suspend, raises busy quickly.
// - Otherwise resume is ignored, nothing changes.
// - Resume ignored after power loss while suspended.
// - Host waits guard time before next suspend.
// - Power-down only if chip select rises after bit eight.
// - Enter power-down within entry delay.
// - Powered down: only release opcode recognised.
// - Power-up always in normal operation.
// - After release, commands accepted after release delay.
// - Host holds chip select high during release.
// - Release opcode, three dummies, then device identifier.
// - Single identifier repeats until chip select rises.
// - Opcode, zero address, manufacturer then device identifier.
// - Dual read: address and identifiers two bits.
// - Quad read: four dummies, address, identifiers four bits.
// - Dual and quad identifiers alternate continuously.
// - Host sends mode bits with upper nibble ones.
// - Four-byte mode uses a 32-bit address (code: dual and quad only, OP_MFR_DEV_ID keeps 24 bits).
// - Unique read: four dummy bytes, 64-bit number.
// - Suspend when busy and not suspended, busy clears.
module flash_id_device
   import flash_id_pkg::*;
#(
   parameter int PD_CYC    = PD_ENTRY_CYC,
   parameter int REL_CYC   = RELEASE_CYC,
   parameter int GUARD_CYC = SUSPEND_GUARD_CYC
) (
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   flash_link_if.device       link,
   input  wire logic          fourByteAddr,
   input  wire logic [7:0]    mfrId,
   input  wire logic [7:0]    devId,
   input  wire logic [63:0]   uniqueId,
   input  wire logic          engineStart,
   input  wire logic          engineDone,
   input  wire logic          powerLost,
   output logic               suspendFlag,
   output logic               busyFlag,
   output logic               resumeReq,
   output logic               suspendReq,
   output logic               powerDown
);
   typedef struct packed {
      logic             csS1;
      logic             csS2;
      logic             csPrev;
      logic             sclkS1;
      logic             sclkS2;
      logic             sclkPrev;
      logic [3:0]       ioS1;
      logic [3:0]       ioS2;
      dev_phase_t       ph;
      logic [7:0]       opcode;
      logic [6:0]       clkCnt;
      logic [5:0]       skipCnt;
      logic [2:0]       outW;
      logic [63:0]      shift;
      logic [3:0]       ioOut;
      logic [3:0]       ioOe;
      logic             suspendFlag;
      logic             busyFlag;
      logic             resumeReq;
      logic             suspendReq;
      logic             powerDown;
      logic [CNT_W-1:0] guardCnt;
      logic [CNT_W-1:0] pdCnt;
      logic [CNT_W-1:0] relCnt;
   } dev_state_t;

   dev_state_t r;
   dev_state_t n;
   logic       csRise;
   logic       sclkRise;
   logic       sclkFall;
   logic       quiet;
   logic [7:0] nextOp;

   always_comb begin
      n            = r;
      n.resumeReq  = 1'b0;
      n.suspendReq = 1'b0;
      n.csS1       = link.csN;
      n.csS2       = r.csS1;
      n.csPrev     = r.csS2;
      n.sclkS1     = link.sclk;
      n.sclkS2     = r.sclkS1;
      n.sclkPrev   = r.sclkS2;
      n.ioS1       = link.io;
      n.ioS2       = r.ioS1;
      csRise       = r.csS2 & ~r.csPrev;
      sclkRise     = r.sclkS2 & ~r.sclkPrev & ~r.csS2;
      sclkFall     = ~r.sclkS2 & r.sclkPrev & ~r.csS2;
      quiet        = r.powerDown | (r.pdCnt != '0) | (r.relCnt != '0);
      nextOp       = {r.opcode[6:0], r.ioS2[0]};

      if (engineDone) begin
         n.busyFlag = 1'b0;
      end
      if (engineStart) begin
         n.busyFlag = 1'b1;
      end
      if (r.guardCnt != '0) begin
         n.guardCnt = r.guardCnt - 1'b1;
         if (r.guardCnt == CNT_W'(1)) begin
            n.busyFlag = 1'b0;
         end
      end
      if (powerLost) begin
         // The lost operation cannot be resumed, so the flag is simply dropped.
         n.suspendFlag = 1'b0;
      end
      if (r.pdCnt != '0) begin
         n.pdCnt = r.pdCnt - 1'b1;
         if (r.pdCnt == CNT_W'(1)) begin
            n.powerDown = 1'b1;
         end
      end
      if (r.relCnt != '0) begin
         n.relCnt = r.relCnt - 1'b1;
         if (r.relCnt == CNT_W'(1)) begin
            n.powerDown = 1'b0;
         end
      end

      if (csRise && r.clkCnt == 7'(OPCODE_BITS)) begin
         unique case (r.opcode)
            OP_RESUME: begin
               if (r.suspendFlag && !r.busyFlag && !quiet) begin
                  n.suspendFlag = 1'b0;
                  n.busyFlag    = 1'b1;
                  n.resumeReq   = 1'b1;
               end
            end
            OP_SUSPEND: begin
               if (r.busyFlag && !r.suspendFlag && !quiet) begin
                  n.suspendFlag = 1'b1;
                  n.suspendReq  = 1'b1;
                  n.guardCnt    = CNT_W'(GUARD_CYC);
               end
            end
            OP_POWER_DOWN: begin
               if (!quiet) begin
                  n.pdCnt = CNT_W'(PD_CYC);
               end
            end
            OP_RELEASE_ID: begin
               if (r.powerDown && r.relCnt == '0) begin
                  n.relCnt = CNT_W'(REL_CYC);
               end
            end
            default: begin
            end
         endcase
      end

      if (r.csS2) begin
         n.ph     = PH_OPC;
         n.clkCnt = '0;
         n.ioOe   = 4'h0;
      end else if (sclkRise) begin
         if (r.clkCnt != 7'h7F) begin
            n.clkCnt = r.clkCnt + 1'b1;
         end
         unique case (r.ph)
            PH_OPC: begin
               n.opcode = nextOp;
               if (r.clkCnt == 7'(OPCODE_BITS - 1)) begin
                  n.ph    = PH_SKIP;
                  n.outW  = 3'd2;
                  n.shift = {4{mfrId, devId}};
                  unique case (nextOp)
                     OP_RELEASE_ID: begin
                        n.skipCnt = SKIP_SINGLE;
                        n.outW    = 3'd1;
                        n.shift   = {8{devId}};
                     end
                     OP_MFR_DEV_ID: begin
                        n.skipCnt = SKIP_SINGLE;
                        n.outW    = 3'd1;
                     end
                     OP_MFR_DEV_DUAL: begin
                        n.skipCnt = fourByteAddr ? SKIP_DUAL4 : SKIP_DUAL3;
                     end
                     OP_MFR_DEV_QUAD: begin
                        n.skipCnt = fourByteAddr ? SKIP_QUAD4 : SKIP_QUAD3;
                        n.outW    = 3'd4;
                     end
                     OP_UNIQUE_ID: begin
                        n.skipCnt = SKIP_UID;
                        n.outW    = 3'd1;
                        n.shift   = uniqueId;
                     end
                     default: begin
                        n.ph = PH_IGNORE;
                     end
                  endcase
                  if (quiet) begin
                     n.ph = PH_IGNORE;
                  end
               end
            end
            PH_SKIP: begin
               n.skipCnt = r.skipCnt - 1'b1;
               if (r.skipCnt == 6'd1) begin
                  n.ph = PH_OUT;
               end
            end
            default: begin
            end
         endcase
      end else if (sclkFall && r.ph == PH_OUT) begin
         // Rotation by the lane width replays the pattern for as long as clocks run.
         unique case (r.outW)
            3'd2: begin
               n.ioOut = {2'b00, r.shift[63:62]};
               n.ioOe  = 4'h3;
               n.shift = {r.shift[61:0], r.shift[63:62]};
            end
            3'd4: begin
               n.ioOut = r.shift[63:60];
               n.ioOe  = 4'hF;
               n.shift = {r.shift[59:0], r.shift[63:60]};
            end
            default: begin
               n.ioOut = {2'b00, r.shift[63], 1'b0};
               n.ioOe  = 4'h2;
               n.shift = {r.shift[62:0], r.shift[63]};
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         r          <= '0;
         r.csS1     <= 1'b1;
         r.csS2     <= 1'b1;
         r.csPrev   <= 1'b1;
         r.ph       <= PH_OPC;
      end else begin
         r <= n;
      end
   end

   assign link.devOut = r.ioOut;
   assign link.devOe  = r.ioOe;
   assign suspendFlag = r.suspendFlag;
   assign busyFlag    = r.busyFlag;
   assign resumeReq   = r.resumeReq;
   assign suspendReq  = r.suspendReq;
   assign powerDown   = r.powerDown;
endmodule : flash_id_device
`default_nettype wire

/* design/flash_id_host.sv */
`timescale 1ns/100ps
`default_nettype none
module flash_id_host
   import flash_id_pkg::*;
#(
   parameter int HALF_CYC  = SCLK_HALF_CYC,
   parameter int REL_CYC   = RELEASE_CYC,
   parameter int GUARD_CYC = SUSPEND_GUARD_CYC
) (
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   flash_link_if.host         link,
   input  wire logic          fourByteAddr,
   input  wire logic          cmdValid,
   input  wire logic [7:0]    cmdOpcode,
   input  wire logic [3:0]    cmdReadBytes,
   output logic               cmdReady,
   output logic               cmdDone,
   output logic [7:0]         rdData,
   output logic               rdValid
);
   typedef struct packed {
      host_state_t      st;
      logic             csN;
      logic             sclk;
      logic [3:0]       ioOut;
      logic [3:0]       ioOe;
      logic [3:0]       ioS1;
      logic [3:0]       ioS2;
      logic [CNT_W-1:0] div;
      logic [CNT_W-1:0] guardCnt;
      logic [7:0]       clkIdx;
      logic [7:0]       total;
      logic [7:0]       readStart;
      logic [7:0]       modeFrom;
      logic [2:0]       wIn;
      logic [2:0]       wOut;
      logic [7:0]       opc;
      logic [7:0]       opcSh;
      logic [7:0]       modeSh;
      logic [7:0]       rdSh;
      logic [3:0]       rdBits;
      logic [7:0]       rdData;
      logic             rdValid;
      logic             done;
      logic             ready;
   } host_state_s_t;

   host_state_s_t r;
   host_state_s_t n;
   logic [5:0]    skip;
   logic [5:0]    modeClks;
   logic [6:0]    outBits;
   logic [7:0]    idx;

   always_comb begin
      n         = r;
      n.rdValid = 1'b0;
      n.done    = 1'b0;
      n.ioS1    = link.io;
      n.ioS2    = r.ioS1;
      skip      = 6'd0;
      modeClks  = 6'd0;
      n.wIn     = 3'd1;
      n.wOut    = 3'd1;
      idx       = r.clkIdx + 1'b1;
      unique case (cmdOpcode)
         OP_RELEASE_ID: skip = (cmdReadBytes != 4'h0) ? SKIP_SINGLE : 6'd0;
         OP_MFR_DEV_ID: skip = SKIP_SINGLE;
         OP_UNIQUE_ID:  skip = SKIP_UID;
         OP_MFR_DEV_DUAL: begin
            skip     = fourByteAddr ? SKIP_DUAL4 : SKIP_DUAL3;
            modeClks = MODE_CLKS_DUAL;
            n.wIn    = 3'd2;
            n.wOut   = 3'd2;
         end
         OP_MFR_DEV_QUAD: begin
            skip     = fourByteAddr ? SKIP_QUAD4 : SKIP_QUAD3;
            modeClks = MODE_CLKS_QUAD;
            n.wIn    = 3'd4;
            n.wOut   = 3'd4;
         end
         default: skip = 6'd0;
      endcase
      outBits = (skip == 6'd0) ? 7'd0 : {cmdReadBytes, 3'b000};
      if (n.wOut == 3'd2) begin
         outBits = {1'b0, outBits[6:1]};
      end else if (n.wOut == 3'd4) begin
         outBits = {2'b00, outBits[6:2]};
      end
      if (r.guardCnt != '0) begin
         n.guardCnt = r.guardCnt - 1'b1;
      end

      unique case (r.st)
         H_IDLE: begin
            // Commands wait while the post-resume guard runs, so no suspend comes early.
            n.ready = (r.guardCnt == '0);
            if (cmdValid && r.ready) begin
               n.ready     = 1'b0;
               n.opc       = cmdOpcode;
               n.readStart = 8'(OPCODE_BITS) + {2'b00, skip};
               n.modeFrom  = n.readStart - {2'b00, modeClks};
               n.total     = n.readStart + {1'b0, outBits};
               n.opcSh     = {cmdOpcode[6:0], 1'b0};
               n.modeSh    = MODE_BITS;
               n.rdBits    = 4'h0;
               n.clkIdx    = 8'h00;
               n.csN       = 1'b0;
               n.sclk      = 1'b0;
               n.ioOut     = {3'b000, cmdOpcode[7]};
               n.ioOe      = 4'h1;
               n.div       = CNT_W'(HALF_CYC - 1);
               n.st        = H_LOW;
            end else begin
               n.wIn  = r.wIn;
               n.wOut = r.wOut;
            end
         end
         H_LOW: begin
            n.wIn  = r.wIn;
            n.wOut = r.wOut;
            if (r.div != '0) begin
               n.div = r.div - 1'b1;
            end else begin
               if (r.clkIdx >= r.readStart) begin
                  unique case (r.wOut)
                     3'd2:    n.rdSh = {r.rdSh[5:0], r.ioS2[1:0]};
                     3'd4:    n.rdSh = {r.rdSh[3:0], r.ioS2};
                     default: n.rdSh = {r.rdSh[6:0], r.ioS2[1]};
                  endcase
                  n.rdBits = r.rdBits + {1'b0, r.wOut};
                  if (n.rdBits == 4'd8) begin
                     n.rdBits  = 4'h0;
                     n.rdData  = n.rdSh;
                     n.rdValid = 1'b1;
                  end
               end
               n.sclk = 1'b1;
               n.div  = CNT_W'(HALF_CYC - 1);
               n.st   = H_HIGH;
            end
         end
         H_HIGH: begin
            n.wIn  = r.wIn;
            n.wOut = r.wOut;
            if (r.div != '0) begin
               n.div = r.div - 1'b1;
            end else begin
               n.sclk   = 1'b0;
               n.clkIdx = idx;
               n.div    = CNT_W'(HALF_CYC - 1);
               n.st     = H_LOW;
               if (idx == r.total) begin
                  n.ioOe = 4'h0;
                  n.st   = H_TAIL;
               end else if (idx < 8'(OPCODE_BITS)) begin
                  n.ioOut = {3'b000, r.opcSh[7]};
                  n.opcSh = {r.opcSh[6:0], 1'b0};
               end else if (idx < r.readStart) begin
                  n.ioOe  = lane_enable(r.wIn);
                  n.ioOut = 4'h0;
                  if (idx >= r.modeFrom) begin
                     n.ioOut  = lane_bits(r.wIn, r.modeSh);
                     n.modeSh = r.modeSh << r.wIn;
                  end
               end else begin
                  n.ioOe = 4'h0;
               end
            end
         end
         H_TAIL: begin
            n.wIn  = r.wIn;
            n.wOut = r.wOut;
            if (r.div != '0) begin
               n.div = r.div - 1'b1;
            end else begin
               n.csN  = 1'b1;
               n.done = 1'b1;
               n.st   = H_GAP;
               n.div  = CNT_W'(2 * HALF_CYC);
               if (r.opc == OP_RELEASE_ID && r.total == 8'(OPCODE_BITS)) begin
                  n.div = CNT_W'(REL_CYC);
               end
               if (r.opc == OP_RESUME) begin
                  n.guardCnt = CNT_W'(GUARD_CYC);
               end
            end
         end
         H_GAP: begin
            n.wIn  = r.wIn;
            n.wOut = r.wOut;
            if (r.div != '0) begin
               n.div = r.div - 1'b1;
            end else begin
               n.st = H_IDLE;
            end
         end
         default: begin
            n.st = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         r     <= '0;
         r.st  <= H_IDLE;
         r.csN <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign link.csN     = r.csN;
   assign link.sclk    = r.sclk;
   assign link.hostOut = r.ioOut;
   assign link.hostOe  = r.ioOe;
   assign cmdReady     = r.ready;
   assign cmdDone      = r.done;
   assign rdData       = r.rdData;
   assign rdValid      = r.rdValid;
endmodule : flash_id_host
`default_nettype wire

/* test/flash_link_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module flash_link_monitor #(
   parameter int GUARD = 40
) (
   input wire logic       ref_clk,
   input wire logic       rst_n,
   input wire logic       csN,
   input wire logic       sclk,
   input wire logic [3:0] hostOe,
   input wire logic [3:0] devOe,
   input wire logic       suspendFlag,
   input wire logic       busyFlag,
   input wire logic       resumeReq,
   input wire logic       suspendReq,
   input wire logic       powerDown
);
   // Two spare cycles cover the flag register behind the guard counter.
   localparam int GUARD_LIM = GUARD + 2;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   sequence resumeSeen;
      resumeReq;
   endsequence
   sequence suspendSeen;
      suspendReq ##0 suspendFlag;
   endsequence
   resume_accept_a: assert property (resumeSeen |-> $past(suspendFlag) && !$past(busyFlag))
      else $error("resume taken in wrong state");
   resume_effect_a: assert property (resumeSeen |-> !suspendFlag && busyFlag)
      else $error("resume did not flip flags");
   suspend_accept_a: assert property (suspendSeen |-> $past(busyFlag) && !$past(suspendFlag))
      else $error("suspend taken in wrong state");
   busy_clear_a: assert property (suspendReq |-> ##[1:GUARD_LIM] !busyFlag)
      else $error("busy not cleared after suspend");
   pd_ignore_a: assert property (powerDown |-> !resumeReq && !suspendReq)
      else $error("command acted while powered down");
   reset_normal_a: assert property ($rose(rst_n) |-> !powerDown)
      else $error("power-down after reset");
   dev_quiet_a: assert property (csN [*6] |-> devOe == 4'h0)
      else $error("device drives lanes while deselected");
   sclk_idle_a: assert property (csN |-> !sclk)
      else $error("serial clock runs while deselected");
   lane_clash_a: assert property ((devOe & hostOe) == 4'h0)
      else $error("both ends drive one lane");
endmodule : flash_link_monitor
`default_nettype wire

/* test/tb_flash_resume_powerdown_id_cmds.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_flash_resume_powerdown_id_cmds;
   import flash_id_pkg::*;
   localparam int PD_C = 20;
   localparam int REL_C = 20;
   localparam int GUARD_C = 40;
   // Identifier values are arbitrary.
   localparam logic [7:0]  MFR = 8'h5C;
   localparam logic [7:0]  DEV = 8'h19;
   localparam logic [63:0] UID = 64'h0123456789ABCDEF;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        fourByteAddr = 1'b0;
   logic        engineStart = 1'b0;
   logic        engineDone = 1'b0;
   logic        powerLost = 1'b0;
   logic        cmdValid = 1'b0;
   logic [7:0]  cmdOpcode = 8'h00;
   logic [3:0]  cmdReadBytes = 4'h0;
   logic        cmdReady, cmdDone, rdValid;
   logic [7:0]  rdData;
   logic        suspendFlag, busyFlag, resumeReq, suspendReq, powerDown;
   logic [7:0]  got [16];
   int          n_errors = 0;
   int          n_checks = 0;
   int          cycles = 0;
   flash_link_if link();
   flash_id_device #(.PD_CYC(PD_C), .REL_CYC(REL_C), .GUARD_CYC(GUARD_C)) flash_id_device_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .link(link), .fourByteAddr(fourByteAddr),
      .mfrId(MFR), .devId(DEV), .uniqueId(UID), .engineStart(engineStart),
      .engineDone(engineDone), .powerLost(powerLost), .suspendFlag(suspendFlag),
      .busyFlag(busyFlag), .resumeReq(resumeReq), .suspendReq(suspendReq),
      .powerDown(powerDown));
   flash_id_host #(.HALF_CYC(8), .REL_CYC(REL_C), .GUARD_CYC(GUARD_C)) flash_id_host_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .link(link), .fourByteAddr(fourByteAddr),
      .cmdValid(cmdValid), .cmdOpcode(cmdOpcode), .cmdReadBytes(cmdReadBytes),
      .cmdReady(cmdReady), .cmdDone(cmdDone), .rdData(rdData), .rdValid(rdValid));
   flash_link_monitor #(.GUARD(GUARD_C)) flash_link_monitor_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .csN(link.csN), .sclk(link.sclk),
      .hostOe(link.hostOe), .devOe(link.devOe), .suspendFlag(suspendFlag),
      .busyFlag(busyFlag), .resumeReq(resumeReq), .suspendReq(suspendReq),
      .powerDown(powerDown));
   always #2.5 ref_clk = ~ref_clk;
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test
   // The ceiling leaves room for all frames plus the guard and delay waits.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_errors++;
         end_of_test();
      end
   end
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      n_checks++;
      if (e !== g) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Runs one frame, keeps the bytes read, then lets the device's synchronisers settle.
   task automatic send(input logic [7:0] op, input int n);
      int k = 0;
      @(posedge ref_clk);
      while (cmdReady !== 1'b1) @(posedge ref_clk);
      cmdOpcode <= op;
      cmdReadBytes <= 4'(n);
      cmdValid <= 1'b1;
      @(posedge ref_clk);
      cmdValid <= 1'b0;
      do begin
         @(posedge ref_clk);
         #1;
         if (rdValid === 1'b1 && k < 16) begin
            got[k] = rdData;
            k++;
         end
      end while (cmdDone !== 1'b1);
      repeat (12) @(posedge ref_clk);
   endtask : send
   task automatic t_id(input logic [7:0] op, input int n, input logic fb);
      logic [7:0] e;
      @(posedge ref_clk) fourByteAddr <= fb;
      send(op, n);
      for (int i = 0; i < n; i++) begin
         if (op == OP_RELEASE_ID) e = DEV;
         else if (op == OP_UNIQUE_ID) e = UID[63 - 8 * i -: 8];
         else e = i[0] ? DEV : MFR;
         chk("id byte", 64'(e), 64'(got[i]));
      end
   endtask : t_id
   task automatic t_flags(input string nm, input logic s, input logic b);
      chk({nm, " suspend"}, 64'(s), 64'(suspendFlag));
      chk({nm, " busy"}, 64'(b), 64'(busyFlag));
   endtask : t_flags
   task automatic t_resume();
      send(OP_RESUME, 0);
      t_flags("idle resume", 1'b0, 1'b0);
      @(posedge ref_clk) engineStart <= 1'b1;
      @(posedge ref_clk) engineStart <= 1'b0;
      send(OP_RESUME, 0);
      t_flags("busy resume", 1'b0, 1'b1);
      send(OP_SUSPEND, 0);
      repeat (GUARD_C + 5) @(posedge ref_clk);
      t_flags("suspend", 1'b1, 1'b0);
      send(OP_RESUME, 0);
      t_flags("resume", 1'b0, 1'b1);
      send(OP_SUSPEND, 0);
      repeat (GUARD_C + 5) @(posedge ref_clk);
      @(posedge ref_clk) powerLost <= 1'b1;
      @(posedge ref_clk) powerLost <= 1'b0;
      send(OP_RESUME, 0);
      t_flags("lost resume", 1'b0, 1'b0);
   endtask : t_resume
   task automatic t_pd();
      send(OP_POWER_DOWN, 0);
      repeat (PD_C + 5) @(posedge ref_clk);
      chk("power down", 64'h1, 64'(powerDown));
      @(posedge ref_clk) engineStart <= 1'b1;
      @(posedge ref_clk) engineStart <= 1'b0;
      send(OP_SUSPEND, 0);
      t_flags("asleep suspend", 1'b0, 1'b1);
      send(OP_MFR_DEV_ID, 2);
      chk("ignored read", 64'hFF, 64'(got[0]));
      send(OP_RELEASE_ID, 0);
      chk("release wait", 64'h1, 64'(powerDown));
      repeat (REL_C) @(posedge ref_clk);
      chk("released", 64'h0, 64'(powerDown));
      t_id(OP_RELEASE_ID, 1, 1'b0);
      send(OP_POWER_DOWN, 0);
      repeat (PD_C + 5) @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk("reset wakes", 64'h0, 64'(powerDown));
   endtask : t_pd
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk("reset power down", 64'h0, 64'(powerDown));
      t_id(OP_RELEASE_ID, 2, 1'b0);
      t_id(OP_MFR_DEV_ID, 2, 1'b0);
      t_id(OP_MFR_DEV_DUAL, 3, 1'b0);
      t_id(OP_MFR_DEV_DUAL, 2, 1'b1);
      t_id(OP_MFR_DEV_QUAD, 3, 1'b0);
      t_id(OP_MFR_DEV_QUAD, 2, 1'b1);
      t_id(OP_UNIQUE_ID, 8, 1'b0);
      t_resume();
      t_pd();
      end_of_test();
   end
endmodule : tb_flash_resume_powerdown_id_cmds
`default_nettype wire
